// ===== common/uart_defs.vh
`ifndef UART_DEFS_VH
`define UART_DEFS_VH

// Register byte addresses
`define ADDR_SERIAL_DATA    32'h4000c800
`define ADDR_UART_CONFIG    32'h4000c804
`define ADDR_BIT_PERIOD     32'h4000c808
`define ADDR_IRQ_FLAGS      32'h4000c80c
`define ADDR_IRQ_ENABLE     32'h4000c810
`define ADDR_IRQ_MODE       32'h4000c814
`define ADDR_TOP_IRQ_EN     32'h4000c818
`define ADDR_DMA_CONTROL    32'h4000c81c
`define ADDR_RX_ERR_OFF_A   32'h4000c820
`define ADDR_RX_ERR_OFF_B   32'h4000c824
`define ADDR_UART_STATUS    32'h4000c848

// Reset values
`define RST_UART_STATUS     32'h00000040
`define RST_UART_CONFIG     7'h00
`define RST_BIT_PERIOD      16'h0008

// Configuration fields
`define CFG_SW_REQUEST      0
`define CFG_FLOW_ENABLE     5
`define CFG_AUTO_REQUEST    6

// Status fields
`define ST_CTS_STATE        0
`define ST_RX_VALID         1
`define ST_TX_SPACE         2
`define ST_RX_OVERRUN       3
`define ST_FRAME_ERR        4
`define ST_PARITY_ERR       5
`define ST_TX_IDLE          6

// Interrupt flag positions
`define IRQ_RX_VALID        0
`define IRQ_TX_SPACE        1
`define IRQ_TX_IDLE         2
`define IRQ_RX_OVERRUN      3
`define IRQ_TX_BUF_A        4
`define IRQ_TX_BUF_B        5
`define IRQ_RX_BUF_A        6
`define IRQ_RX_BUF_B        7
`define IRQ_PARITY          8
`define IRQ_FRAME           9
`define IRQ_COUNT           10

// Sizes and counts
`define FIFO_DEPTH          3'd4
`define RTS_MIN_ROOM        3'd2
`define OVERRUN_LEAD        16'd4
`define TX_FRAME_BITS       4'd10

`endif

// ===== hdl/uart_fifo4.v
`timescale 1ns/1ps
`include "uart_defs.vh"

module uart_fifo4 (
	// Clock and reset
	input  wire        clk,
	input  wire        rst,
	// Write side
	input  wire        push,
	input  wire [9:0]  din,
	// Read side
	input  wire        pop,
	output wire [9:0]  dout,
	// Fill level
	output wire [2:0]  count
);
	reg [9:0] mem [0:3];
	reg [1:0] wptr_r;
	reg [1:0] rptr_r;
	reg [2:0] count_r;
	wire      do_push;
	wire      do_pop;

	assign do_pop  = pop && (count_r != 3'd0);
	// A push into a full FIFO is dropped; only the receive caller reports it, as overrun
	assign do_push = push && (count_r != `FIFO_DEPTH);
	assign dout    = mem[rptr_r];
	assign count   = count_r;

	always @(posedge clk) begin
		if (do_push)
			mem[wptr_r] <= din;
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			wptr_r  <= 2'd0;
			rptr_r  <= 2'd0;
			count_r <= 3'd0;
		end else begin
			if (do_push)
				wptr_r <= wptr_r + 2'd1;
			if (do_pop)
				rptr_r <= rptr_r + 2'd1;
			if (do_push && !do_pop)
				count_r <= count_r + 3'd1;
			else if (do_pop && !do_push)
				count_r <= count_r - 3'd1;
		end
	end
endmodule

// ===== hdl/uart_fifo_flow_status.v
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`include "uart_defs.vh"

module uart_fifo_flow_status (
	// Clock and reset
	input  wire        CLK,
	input  wire        RESET,
	// APB slave
	input  wire        PSEL,
	input  wire        PENABLE,
	input  wire        PWRITE,
	input  wire [31:0] PADDR,
	input  wire [31:0] PWDATA,
	output reg  [31:0] PRDATA,
	output reg         PREADY,
	output reg         PSLVERR,
	// Serial line
	output reg         TXD,
	input  wire        CLEAR_TO_SEND_IN_N,
	output reg         REQUEST_TO_SEND_OUT_N,
	// Received characters from the deserializer
	input  wire        RX_STB,
	input  wire [7:0]  RX_DATA,
	input  wire        RX_PERR,
	input  wire        RX_FERR,
	// Transmit DMA channel
	input  wire        DMA_TX_REQ,
	input  wire [7:0]  DMA_TX_DATA,
	output reg         DMA_TX_ACK,
	input  wire        TX_BUF_ACTIVE_A,
	input  wire        TX_BUF_ACTIVE_B,
	// Receive DMA channel
	input  wire        DMA_RX_REQ,
	output reg         DMA_RX_ACK,
	output reg  [7:0]  DMA_RX_DATA,
	input  wire        DMA_RX_BUF,
	input  wire [15:0] DMA_RX_OFFSET,
	input  wire        DMA_RX_LOAD_A,
	input  wire        DMA_RX_LOAD_B,
	input  wire        RX_BUF_ACTIVE_A,
	input  wire        RX_BUF_ACTIVE_B,
	// Interrupt to processor
	output reg         IRQ
);
	// Registers
	reg  [6:0]  uart_config_r;
	reg  [15:0] bit_period_r;
	reg  [9:0]  irq_flags_r;
	reg  [9:0]  irq_enable_r;
	reg  [2:0]  irq_mode_r;
	reg         top_irq_en_r;
	reg         rx_overrun_r;
	reg  [16:0] err_off_a_r;
	reg  [16:0] err_off_b_r;
	// Line side
	reg         cts_meta_r;
	reg         cts_sync_r;
	reg  [9:0]  tx_shift_r;
	reg  [3:0]  tx_bits_r;
	reg  [15:0] tx_timer_r;
	reg         tx_busy_r;
	// Edge history
	reg  [2:0]  lvl_prev_r;
	reg  [3:0]  act_prev_r;
	wire        flow_ctrl_enable;
	wire        auto_request_ctrl;
	wire        sw_request_bit;
	wire [2:0]  tx_count;
	wire [2:0]  rx_count;
	wire [9:0]  tx_head;
	wire [9:0]  rx_head;
	wire        apb_access;
	wire        apb_done;
	wire        apb_wr;
	wire        apb_rd;
	wire        sw_tx_push;
	wire        sw_rx_pop;
	wire        dma_tx_push;
	wire        dma_rx_pop;
	wire        tx_push;
	wire        rx_pop;
	wire        rx_lost;
	wire        tx_start;
	wire        cts_state_flag;
	wire        tx_idle_flag;
	wire        tx_space_flag;
	wire        rx_valid_flag;
	wire        parity_error_flag;
	wire        frame_error_flag;
	wire [31:0] uart_status;
	wire [2:0]  lvl_now;
	wire [3:0]  act_now;
	wire        dma_err_char;
	wire        rx_dma_reset_a;
	wire        rx_dma_reset_b;
	reg  [9:0]  irq_set;
	reg  [31:0] rdata_nxt;
	reg         addr_ok;
	function sel;
		input [31:0] a;
		input [31:0] b;
		begin
			sel = (a == b);
		end
	endfunction
	assign flow_ctrl_enable  = uart_config_r[`CFG_FLOW_ENABLE];
	assign auto_request_ctrl = uart_config_r[`CFG_AUTO_REQUEST];
	assign sw_request_bit    = uart_config_r[`CFG_SW_REQUEST];
	// Effects land only at the edge the master samples PREADY high
	assign apb_access = PSEL && PENABLE;
	assign apb_done   = apb_access && PREADY;
	assign apb_wr     = apb_done && PWRITE;
	assign apb_rd     = apb_done && !PWRITE;
	assign sw_tx_push  = apb_wr && sel(PADDR, `ADDR_SERIAL_DATA);
	assign sw_rx_pop   = apb_rd && sel(PADDR, `ADDR_SERIAL_DATA);
	// Software has priority; a refused DMA request simply gets no ack
	assign dma_tx_push = DMA_TX_REQ && !sw_tx_push &&
		(tx_count != `FIFO_DEPTH);
	assign dma_rx_pop  = DMA_RX_REQ && !sw_rx_pop &&
		(rx_count != 3'd0);
	assign tx_push     = sw_tx_push || dma_tx_push;
	assign rx_pop      = sw_rx_pop || dma_rx_pop;
	// A pop in the same cycle does not make room; the FIFO counts it full
	assign rx_lost     = RX_STB && (rx_count == `FIFO_DEPTH);
	uart_fifo4 tx_fifo (
		.clk   (CLK),
		.rst   (RESET),
		.push  (tx_push),
		.din   ({2'b00, sw_tx_push ? PWDATA[7:0] : DMA_TX_DATA}),
		.pop   (tx_start),
		.dout  (tx_head),
		.count (tx_count)
	);
	uart_fifo4 rx_fifo (
		.clk   (CLK),
		.rst   (RESET),
		.push  (RX_STB),
		.din   ({RX_FERR, RX_PERR, RX_DATA}),
		.pop   (rx_pop),
		.dout  (rx_head),
		.count (rx_count)
	);
	// Status
	assign cts_state_flag    = ~cts_sync_r;
	assign tx_idle_flag      = (tx_count == 3'd0) && !tx_busy_r;
	assign tx_space_flag     = (tx_count != `FIFO_DEPTH);
	assign rx_valid_flag     = (rx_count != 3'd0);
	assign parity_error_flag = rx_valid_flag && rx_head[8];
	assign frame_error_flag  = rx_valid_flag && rx_head[9];
	assign uart_status = {25'h0000000, tx_idle_flag, parity_error_flag,
		frame_error_flag, rx_overrun_r, tx_space_flag, rx_valid_flag,
		cts_state_flag};
	// Transmit start gate: CTS only matters with flow control on
	assign tx_start = !tx_busy_r && (tx_count != 3'd0) &&
		(!flow_ctrl_enable || cts_state_flag);
	// Interrupt sources
	assign lvl_now = {tx_idle_flag, tx_space_flag, rx_valid_flag};
	assign act_now = {RX_BUF_ACTIVE_B, RX_BUF_ACTIVE_A,
		TX_BUF_ACTIVE_B, TX_BUF_ACTIVE_A};
	assign dma_err_char   = dma_rx_pop && (rx_head[8] || rx_head[9]);
	assign rx_dma_reset_a = apb_wr && sel(PADDR, `ADDR_DMA_CONTROL) &&
		PWDATA[0];
	assign rx_dma_reset_b = apb_wr && sel(PADDR, `ADDR_DMA_CONTROL) &&
		PWDATA[1];
	integer i;
	always @* begin
		irq_set = 10'h000;
		for (i = 0; i < 3; i = i + 1)
			irq_set[i] = irq_mode_r[i] ? lvl_now[i] :
				(lvl_now[i] && !lvl_prev_r[i]);
		irq_set[`IRQ_RX_OVERRUN] = rx_lost;
		irq_set[7:4] = act_prev_r & ~act_now;
		irq_set[`IRQ_PARITY] = RX_STB && RX_PERR;
		irq_set[`IRQ_FRAME]  = RX_STB && RX_FERR;
	end
	// Read mux and address check
	always @* begin
		rdata_nxt = 32'h00000000;
		addr_ok   = 1'b1;
		case (PADDR)
		`ADDR_SERIAL_DATA: rdata_nxt = {24'h000000, rx_head[7:0]};
		`ADDR_UART_CONFIG: rdata_nxt = {25'h0000000, uart_config_r};
		`ADDR_BIT_PERIOD:  rdata_nxt = {16'h0000, bit_period_r};
		`ADDR_IRQ_FLAGS:   rdata_nxt = {22'h000000, irq_flags_r};
		`ADDR_IRQ_ENABLE:  rdata_nxt = {22'h000000, irq_enable_r};
		`ADDR_IRQ_MODE:    rdata_nxt = {29'h00000000, irq_mode_r};
		`ADDR_TOP_IRQ_EN:  rdata_nxt = {31'h00000000, top_irq_en_r};
		`ADDR_DMA_CONTROL: rdata_nxt = 32'h00000000;
		`ADDR_RX_ERR_OFF_A: rdata_nxt = {15'h0000, err_off_a_r};
		`ADDR_RX_ERR_OFF_B: rdata_nxt = {15'h0000, err_off_b_r};
		`ADDR_UART_STATUS: rdata_nxt = uart_status;
		default:           addr_ok = 1'b0;
		endcase
	end

	// APB: one wait state, answer registered
	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			PREADY  <= 1'b0;
			PRDATA  <= 32'h00000000;
			PSLVERR <= 1'b0;
		end else if (apb_access && !PREADY) begin
			PREADY  <= 1'b1;
			PRDATA  <= PWRITE ? 32'h00000000 : rdata_nxt;
			PSLVERR <= !addr_ok;
		end else begin
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
		end
	end

	// Software registers
	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			uart_config_r <= `RST_UART_CONFIG;
			bit_period_r  <= `RST_BIT_PERIOD;
			irq_enable_r  <= 10'h000;
			irq_mode_r    <= 3'h0;
			top_irq_en_r  <= 1'b0;
		end else if (apb_wr) begin
			if (sel(PADDR, `ADDR_UART_CONFIG))
				uart_config_r <= PWDATA[6:0];
			if (sel(PADDR, `ADDR_BIT_PERIOD))
				bit_period_r <= PWDATA[15:0];
			if (sel(PADDR, `ADDR_IRQ_ENABLE))
				irq_enable_r <= PWDATA[9:0];
			if (sel(PADDR, `ADDR_IRQ_MODE))
				irq_mode_r <= PWDATA[2:0];
			if (sel(PADDR, `ADDR_TOP_IRQ_EN))
				top_irq_en_r <= PWDATA[0];
		end
	end

	// Sticky flags; a new event wins over a clear in the same cycle
	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			irq_flags_r  <= 10'h000;
			rx_overrun_r <= 1'b0;
			lvl_prev_r   <= 3'h6; // Idle levels: no false edge after reset
			act_prev_r   <= 4'h0;
			IRQ          <= 1'b0;
		end else begin
			if (apb_wr && sel(PADDR, `ADDR_IRQ_FLAGS))
				irq_flags_r <= (irq_flags_r & ~PWDATA[9:0]) | irq_set;
			else
				irq_flags_r <= irq_flags_r | irq_set;
			if (rx_lost)
				rx_overrun_r <= 1'b1;
			else if (sw_rx_pop)
				rx_overrun_r <= 1'b0;
			lvl_prev_r <= lvl_now;
			act_prev_r <= act_now;
			IRQ <= top_irq_en_r && |(irq_flags_r & irq_enable_r);
		end
	end

	// Receive error offsets: bit 16 marks a recorded offset
	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			err_off_a_r <= 17'h00000;
			err_off_b_r <= 17'h00000;
		end else begin
			if ((dma_err_char || rx_lost) && !DMA_RX_BUF &&
				!err_off_a_r[16])
				err_off_a_r <= {1'b1, rx_lost ?
					DMA_RX_OFFSET + `OVERRUN_LEAD :
					DMA_RX_OFFSET};
			else if (rx_dma_reset_a || DMA_RX_LOAD_A)
				err_off_a_r <= 17'h00000;
			if ((dma_err_char || rx_lost) && DMA_RX_BUF &&
				!err_off_b_r[16])
				err_off_b_r <= {1'b1, rx_lost ?
					DMA_RX_OFFSET + `OVERRUN_LEAD :
					DMA_RX_OFFSET};
			else if (rx_dma_reset_b || DMA_RX_LOAD_B)
				err_off_b_r <= 17'h00000;
		end
	end
	// DMA handshakes
	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			DMA_TX_ACK  <= 1'b0;
			DMA_RX_ACK  <= 1'b0;
			DMA_RX_DATA <= 8'h00;
		end else begin
			DMA_TX_ACK <= dma_tx_push;
			DMA_RX_ACK <= dma_rx_pop;
			if (dma_rx_pop)
				DMA_RX_DATA <= rx_head[7:0];
		end
	end
	// Line inputs and RTS
	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			cts_meta_r            <= 1'b1;
			cts_sync_r            <= 1'b1;
			REQUEST_TO_SEND_OUT_N <= 1'b1;
		end else begin
			cts_meta_r <= CLEAR_TO_SEND_IN_N;
			cts_sync_r <= cts_meta_r;
			if (!flow_ctrl_enable)
				REQUEST_TO_SEND_OUT_N <= 1'b1;
			else if (auto_request_ctrl)
				REQUEST_TO_SEND_OUT_N <=
					!((`FIFO_DEPTH - rx_count) >= `RTS_MIN_ROOM);
			else
				REQUEST_TO_SEND_OUT_N <= !sw_request_bit;
		end
	end
	// Transmit shifter: start, 8 data, stop; CTS is not looked at once busy
	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			tx_shift_r <= 10'h3ff;
			tx_bits_r  <= 4'h0;
			tx_timer_r <= 16'h0000;
			tx_busy_r  <= 1'b0;
			TXD        <= 1'b1;
		end else if (tx_start) begin
			tx_shift_r <= {1'b1, tx_head[7:0], 1'b0};
			tx_bits_r  <= `TX_FRAME_BITS;
			tx_timer_r <= 16'h0000;
			tx_busy_r  <= 1'b1;
		end else if (tx_busy_r) begin
			if (tx_timer_r == 16'h0000) begin
				TXD        <= tx_shift_r[0];
				tx_shift_r <= {1'b1, tx_shift_r[9:1]};
				tx_timer_r <= bit_period_r;
				if (tx_bits_r == 4'h0)
					tx_busy_r <= 1'b0;
				else
					tx_bits_r <= tx_bits_r - 4'h1;
			end else begin
				tx_timer_r <= tx_timer_r - 16'h0001;
			end
		end else begin
			TXD <= 1'b1;
		end
	end
endmodule

// ===== test/uart_asserts.sv
`timescale 1ns/1ps
`include "uart_defs.vh"
module uart_asserts (
	// Clock and reset
	input wire        CLK,
	input wire        RESET,
	// Register bus
	input wire        PSEL,
	input wire        PENABLE,
	input wire        PWRITE,
	input wire [31:0] PADDR,
	input wire [31:0] PWDATA,
	input wire        PREADY,
	input wire        PSLVERR,
	// Line and channels
	input wire        TXD,
	input wire        CLEAR_TO_SEND_IN_N,
	input wire        REQUEST_TO_SEND_OUT_N,
	input wire        DMA_TX_REQ,
	input wire        DMA_TX_ACK,
	input wire        DMA_RX_REQ,
	input wire        DMA_RX_ACK,
	input wire        IRQ
);
	reg  [6:0] cfg_r;
	reg  [6:0] cfg_d;
	reg        top_r;
	reg        txd_q;
	reg  [6:0] fcnt_r;
	wire       wr = PSEL & PENABLE & PREADY & PWRITE;
	wire       start = txd_q & ~TXD & (fcnt_r == 7'd0);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);
	// Frame timing holds only for the reset bit period of nine cycles
	always @(posedge CLK or posedge RESET) begin
		if (RESET) begin
			cfg_r <= 7'h00;
			cfg_d <= 7'h00;
			top_r <= 1'b0;
			txd_q <= 1'b1;
			fcnt_r <= 7'd0;
		end else begin
			if (wr && PADDR == `ADDR_UART_CONFIG)
				cfg_r <= PWDATA[6:0];
			if (wr && PADDR == `ADDR_TOP_IRQ_EN)
				top_r <= PWDATA[0];
			cfg_d <= cfg_r;
			txd_q <= TXD;
			fcnt_r <= start ? 7'd89 : fcnt_r - (fcnt_r != 7'd0);
		end
	end
	property p_ready_one;
		PREADY |=> !PREADY;
	endproperty
	a_ready_one: assert property (p_ready_one)
		else $error("ready longer than one cycle");
	property p_wait;
		PSEL && PENABLE && !$past(PENABLE) |-> !PREADY ##1 PREADY;
	endproperty
	a_wait: assert property (p_wait)
		else $error("wait state broken");
	property p_err;
		PSLVERR |-> PREADY;
	endproperty
	a_err: assert property (p_err)
		else $error("error without ready");
	property p_start_len;
		start |-> !TXD ##1 !TXD [*8];
	endproperty
	a_start_len: assert property (p_start_len)
		else $error("start bit short");
	property p_stop;
		start |-> ##81 TXD [*8];
	endproperty
	a_stop: assert property (p_stop)
		else $error("frame not finished");
	property p_cts_gate;
		start && cfg_r[5] && cfg_d[5] |-> !$past(CLEAR_TO_SEND_IN_N, 2) ||
			!$past(CLEAR_TO_SEND_IN_N, 3) || !$past(CLEAR_TO_SEND_IN_N, 4);
	endproperty
	a_cts_gate: assert property (p_cts_gate)
		else $error("start while clear to send high");
	property p_rts_off;
		!cfg_r[5] && !cfg_d[5] |-> REQUEST_TO_SEND_OUT_N;
	endproperty
	a_rts_off: assert property (p_rts_off)
		else $error("request low with flow off");
	property p_rts_sw;
		cfg_r[5] && !cfg_r[6] && cfg_r == cfg_d |->
			REQUEST_TO_SEND_OUT_N == !cfg_r[0];
	endproperty
	a_rts_sw: assert property (p_rts_sw)
		else $error("request not following software bit");
	property p_irq_top;
		!top_r && !$past(top_r) |-> !IRQ;
	endproperty
	a_irq_top: assert property (p_irq_top)
		else $error("interrupt with top enable clear");
	property p_tx_ack;
		DMA_TX_ACK |-> $past(DMA_TX_REQ);
	endproperty
	a_tx_ack: assert property (p_tx_ack)
		else $error("transmit ack without request");
	property p_rx_ack;
		DMA_RX_ACK |-> $past(DMA_RX_REQ);
	endproperty
	a_rx_ack: assert property (p_rx_ack)
		else $error("receive ack without request");
	c_read: cover property (PREADY && !PWRITE);
	c_start: cover property (start && cfg_r[5]);
	c_irq: cover property ($rose(IRQ));
endmodule
bind uart_fifo_flow_status uart_asserts i_chk (.CLK(CLK), .RESET(RESET),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
	.PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .TXD(TXD),
	.CLEAR_TO_SEND_IN_N(CLEAR_TO_SEND_IN_N),
	.REQUEST_TO_SEND_OUT_N(REQUEST_TO_SEND_OUT_N),
	.DMA_TX_REQ(DMA_TX_REQ), .DMA_TX_ACK(DMA_TX_ACK),
	.DMA_RX_REQ(DMA_RX_REQ), .DMA_RX_ACK(DMA_RX_ACK), .IRQ(IRQ));

// ===== test/uart_peer.sv
`timescale 1ns/1ps
module uart_peer (
	// Clock
	input  wire       clk,
	// From the block
	input  wire       txd,
	input  wire       rts_n,
	// Bench commands
	input  wire       hold,
	input  wire       rude,
	// To the block
	output reg        cts_n = 1'b1,
	output reg        rx_stb = 1'b0,
	output reg  [7:0] rx_data = 8'h00,
	output reg        rx_perr = 1'b0,
	output reg        rx_ferr = 1'b0
);
	reg [7:0] got [0:15];
	reg [7:0] sh;
	integer   n = 0;
	integer   b;
	always @(posedge clk)
		cts_n <= hold;
	// Mid-bit sampling assumes the reset bit period
	always begin
		@(negedge txd);
		repeat (4) @(posedge clk);
		for (b = 0; b < 8; b = b + 1) begin
			repeat (9) @(posedge clk);
			sh = {txd, sh[7:1]};
		end
		repeat (9) @(posedge clk);
		got[n] = sh;
		n = n + 1;
	end
	task send(input [7:0] d, input p, input f);
		integer i;
		begin
			i = 0;
			while (rts_n && !rude && i < 1000) begin
				@(posedge clk);
				i = i + 1;
			end
			if (i >= 1000)
				uart_fifo_flow_status_tb.tmo;
			@(posedge clk);
			rx_stb <= 1'b1;
			rx_data <= d;
			rx_perr <= p;
			rx_ferr <= f;
			@(posedge clk);
			rx_stb <= 1'b0;
			// Stale values would hide a missing strobe qualifier
			rx_data <= ~d;
			rx_perr <= ~p;
			rx_ferr <= ~f;
		end
	endtask
endmodule

// ===== test/uart_fifo_flow_status_tb.sv
`timescale 1ns/1ps
`include "uart_defs.vh"
module uart_fifo_flow_status_tb;
	localparam [31:0] ST = `ADDR_UART_STATUS;
	localparam [31:0] DT = `ADDR_SERIAL_DATA;
	localparam [31:0] FL = `ADDR_IRQ_FLAGS;
	localparam [31:0] EA = `ADDR_RX_ERR_OFF_A;
	localparam [31:0] EB = `ADDR_RX_ERR_OFF_B;
	localparam [31:0] CFGS = 32'h60002021;
	localparam [3:0]  RTSX = 4'b0110;
	localparam [31:0] RXS = 32'h45475767;
	reg         CLK = 1'b0;
	reg         RESET = 1'b1;
	reg         PSEL = 1'b0;
	reg         PENABLE = 1'b0;
	reg         PWRITE = 1'b0;
	reg  [31:0] PADDR = 32'h0;
	reg  [31:0] PWDATA = 32'h0;
	wire [31:0] PRDATA;
	wire        PREADY;
	wire        PSLVERR;
	wire        TXD;
	wire        CTS_N;
	wire        RTS_N;
	wire        RX_STB;
	wire [7:0]  RX_DATA;
	wire        RX_PERR;
	wire        RX_FERR;
	reg         DMA_TX_REQ = 1'b0;
	reg  [7:0]  DMA_TX_DATA = 8'h00;
	wire        DMA_TX_ACK;
	reg         DMA_RX_REQ = 1'b0;
	wire        DMA_RX_ACK;
	wire [7:0]  DMA_RX_DATA;
	reg  [15:0] DMA_RX_OFFSET = 16'h0;
	reg         load_a = 1'b0;
	reg         load_b = 1'b0;
	reg         rxb = 1'b0;
	reg  [3:0]  bufs = 4'h0;
	wire        IRQ;
	reg         hold = 1'b1;
	reg         rude = 1'b0;
	reg  [31:0] rd;
	reg         er;
	integer     n_mismatch = 0;
	integer     tests_run = 0;
	integer     k;
	always #12.5 CLK = ~CLK;
	uart_fifo_flow_status i_dut (.CLK(CLK), .RESET(RESET), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
		.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .TXD(TXD),
		.CLEAR_TO_SEND_IN_N(CTS_N), .REQUEST_TO_SEND_OUT_N(RTS_N),
		.RX_STB(RX_STB), .RX_DATA(RX_DATA), .RX_PERR(RX_PERR),
		.RX_FERR(RX_FERR), .DMA_TX_REQ(DMA_TX_REQ),
		.DMA_TX_DATA(DMA_TX_DATA), .DMA_TX_ACK(DMA_TX_ACK),
		.TX_BUF_ACTIVE_A(bufs[0]), .TX_BUF_ACTIVE_B(bufs[1]),
		.DMA_RX_REQ(DMA_RX_REQ), .DMA_RX_ACK(DMA_RX_ACK),
		.DMA_RX_DATA(DMA_RX_DATA), .DMA_RX_BUF(rxb),
		.DMA_RX_OFFSET(DMA_RX_OFFSET), .DMA_RX_LOAD_A(load_a),
		.DMA_RX_LOAD_B(load_b), .RX_BUF_ACTIVE_A(bufs[2]),
		.RX_BUF_ACTIVE_B(bufs[3]), .IRQ(IRQ));
	uart_peer i_peer (.clk(CLK), .txd(TXD), .rts_n(RTS_N), .hold(hold),
		.rude(rude), .cts_n(CTS_N), .rx_stb(RX_STB), .rx_data(RX_DATA),
		.rx_perr(RX_PERR), .rx_ferr(RX_FERR));
	task wrap_up;
		begin
			$display("checks %0d mismatches %0d", tests_run, n_mismatch);
			if (n_mismatch == 0 && tests_run > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	task tmo;
		begin
			n_mismatch = n_mismatch + 1;
			$display("MISMATCH t=%0t timeout", $time);
			wrap_up;
		end
	endtask
	task chk(input [31:0] g, input [31:0] e, input string m);
		begin
			tests_run = tests_run + 1;
			if (g !== e) begin
				n_mismatch = n_mismatch + 1;
				$display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
			end
		end
	endtask
	task cyc(input integer c);
		repeat (c) @(posedge CLK);
	endtask
	// Idles one cycle after each transfer so no strobe is set twice at once
	task apb(input w, input [31:0] a, input [31:0] d);
		integer i;
		begin
			PSEL <= 1'b1;
			PENABLE <= 1'b0;
			PWRITE <= w;
			PADDR <= a;
			PWDATA <= d;
			@(posedge CLK);
			PENABLE <= 1'b1;
			i = 0;
			do begin
				@(posedge CLK);
				i = i + 1;
			end while (PREADY !== 1'b1 && i < 20);
			if (i >= 20)
				tmo;
			rd = PRDATA;
			er = PSLVERR;
			PSEL <= 1'b0;
			PENABLE <= 1'b0;
			@(posedge CLK);
		end
	endtask
	task rdc(input [31:0] a, input [31:0] m, input [31:0] e, input string s);
		begin
			apb(1'b0, a, 32'h0);
			chk(rd & m, e, s);
		end
	endtask
	task waitn(input integer c);
		integer i;
		begin
			for (i = 0; i < 3000 && i_peer.n < c; i = i + 1)
				@(posedge CLK);
			if (i >= 3000)
				tmo;
		end
	endtask
	task waitack(input rx);
		integer i;
		begin
			i = 0;
			do begin
				@(posedge CLK);
				i = i + 1;
			end while ((rx ? DMA_RX_ACK : DMA_TX_ACK) !== 1'b1 && i < 10);
			if (i >= 10)
				tmo;
		end
	endtask
	initial begin
		#2500000;
		tmo;
	end
	initial begin
		cyc(4);
		RESET <= 1'b0;
		cyc(4);
		rdc(ST, 32'hffffffff, 32'h44, "reset status");
		apb(1'b0, 32'h4000c8f0, 32'h0);
		chk({31'h0, er}, 32'h1, "unmapped");
		for (k = 0; k < 5; k = k + 1)
			apb(1'b1, DT, 32'h10 + k);
		rdc(ST, 32'h7f, 32'h00, "tx full");
		waitn(5);
		for (k = 0; k < 5; k = k + 1)
			chk({24'h0, i_peer.got[k]}, 32'h10 + k, "tx char");
		cyc(10);
		rdc(ST, 32'h7f, 32'h44, "tx idle");
		$display("tx fifo done");
		apb(1'b1, `ADDR_UART_CONFIG, 32'h20);
		apb(1'b1, DT, 32'h3c);
		cyc(200);
		chk(i_peer.n, 32'd5, "cts hold");
		hold <= 1'b0;
		waitn(6);
		chk({24'h0, i_peer.got[5]}, 32'h3c, "cts released");
		apb(1'b1, DT, 32'h5a);
		apb(1'b1, DT, 32'h66);
		for (k = 0; k < 50 && TXD !== 1'b0; k = k + 1)
			@(posedge CLK);
		if (k >= 50)
			tmo;
		hold <= 1'b1;
		waitn(7);
		chk({24'h0, i_peer.got[6]}, 32'h5a, "finish char");
		cyc(200);
		chk(i_peer.n, 32'd7, "next held");
		hold <= 1'b0;
		waitn(8);
		chk({24'h0, i_peer.got[7]}, 32'h66, "released");
		$display("cts done");
		for (k = 0; k < 4; k = k + 1) begin
			apb(1'b1, `ADDR_UART_CONFIG, {24'h0, CFGS[8*k +: 8]});
			cyc(3);
			chk({31'h0, RTS_N}, {31'h0, RTSX[k]}, "rts");
		end
		for (k = 0; k < 3; k = k + 1)
			i_peer.send(8'ha1 + k, k == 1, k == 2);
		cyc(3);
		chk({31'h0, RTS_N}, 32'h1, "rts full");
		rude <= 1'b1;
		i_peer.send(8'ha4, 1'b0, 1'b0);
		i_peer.send(8'ha5, 1'b0, 1'b0);
		rude <= 1'b0;
		rdc(ST, 32'h7f, 32'h4f, "overrun");
		rdc(FL, 32'h308, 32'h308, "err flags");
		for (k = 0; k < 4; k = k + 1) begin
			rdc(DT, 32'hff, 32'ha1 + k, "rx data");
			rdc(ST, 32'h7f, {24'h0, RXS[8*k +: 8]}, "rx st");
		end
		$display("rx done");
		DMA_TX_DATA <= 8'h77;
		DMA_TX_REQ <= 1'b1;
		@(posedge CLK);
		DMA_TX_REQ <= 1'b0;
		waitack(1'b0);
		waitn(9);
		chk({24'h0, i_peer.got[8]}, 32'h77, "dma tx");
		rdc(EA, 32'h1ffff, 32'h10004, "overrun offset");
		apb(1'b1, `ADDR_DMA_CONTROL, 32'h1);
		rdc(EA, 32'h1ffff, 32'h0, "dma reset");
		for (k = 0; k < 2; k = k + 1) begin
			DMA_RX_OFFSET <= 16'h7 + k;
			i_peer.send(8'hb1 + k, k == 1, k == 0);
			DMA_RX_REQ <= 1'b1;
			@(posedge CLK);
			DMA_RX_REQ <= 1'b0;
			waitack(1'b1);
			chk({24'h0, DMA_RX_DATA}, 32'hb1 + k, "dma rx");
			rdc(EA, 32'h1ffff, 32'h10007, "err offset");
		end
		load_a <= 1'b1;
		@(posedge CLK);
		load_a <= 1'b0;
		rdc(EA, 32'h1ffff, 32'h0, "load clear");
		rxb <= 1'b1;
		DMA_RX_OFFSET <= 16'h3;
		i_peer.send(8'hb3, 1'b1, 1'b0);
		DMA_RX_REQ <= 1'b1;
		@(posedge CLK);
		DMA_RX_REQ <= 1'b0;
		waitack(1'b1);
		chk({24'h0, DMA_RX_DATA}, 32'hb3, "dma rx b");
		rdc(EB, 32'h1ffff, 32'h10003, "err offset b");
		rdc(EA, 32'h1ffff, 32'h0, "a untouched");
		load_b <= 1'b1;
		@(posedge CLK);
		load_b <= 1'b0;
		rdc(EB, 32'h1ffff, 32'h0, "load clear b");
		$display("dma done");
		apb(1'b1, FL, 32'h3ff);
		apb(1'b1, `ADDR_IRQ_ENABLE, 32'h1);
		i_peer.send(8'hc1, 1'b0, 1'b0);
		cyc(4);
		chk({31'h0, IRQ}, 32'h0, "top off");
		apb(1'b1, `ADDR_TOP_IRQ_EN, 32'h1);
		cyc(3);
		chk({31'h0, IRQ}, 32'h1, "irq on");
		apb(1'b1, FL, 32'h1);
		cyc(3);
		chk({31'h0, IRQ}, 32'h0, "edge mode");
		apb(1'b1, `ADDR_IRQ_MODE, 32'h1);
		cyc(3);
		chk({31'h0, IRQ}, 32'h1, "level mode");
		rdc(DT, 32'hff, 32'hc1, "irq char");
		apb(1'b1, FL, 32'h1);
		cyc(3);
		chk({31'h0, IRQ}, 32'h0, "level gone");
		for (k = 0; k < 4; k = k + 1) begin
			bufs[k] <= 1'b1;
			cyc(2);
			bufs[k] <= 1'b0;
			cyc(2);
			rdc(FL, 32'h10 << k, 32'h10 << k, "buf done");
		end
		rdc(FL, 32'h4, 32'h0, "tx idle quiet");
		apb(1'b1, DT, 32'h99);
		waitn(10);
		cyc(10);
		rdc(FL, 32'h4, 32'h4, "tx idle irq");
		$display("irq done");
		wrap_up;
	end
endmodule
